// [core/tpc_timer.sv]
// Module: 8-bit timer/counter with shared timer/watchdog prescaler and its configuration
`timescale 1ns/1ns
module tpc_timer
    import tpc_pkg::*;
#(
    parameter int PRESCALE_WIDTH = tpc_pkg::TPC_PRESCALE_W
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // Configuration-load instruction
    input  wire logic                       cfgLoad,
    input  wire logic [7:0]                 accumulator,
    // File register access
    input  wire logic [tpc_pkg::TPC_FILE_AW-1:0] fileAddr,
    input  wire logic                       fileWrite,
    input  wire logic                       fileRead,
    input  wire logic [7:0]                 fileWdata,
    output logic      [7:0]                 fileRdata,
    // External count pin
    input  wire logic                       externalCountInput,
    // Watchdog base tick and prescaled tick
    input  wire logic                       watchdogBaseTick,
    output logic                            watchdogPrescaledTick,
    // Status
    output logic      [7:0]                 timerCount,
    output logic                            instructionClockOut,
    output tpc_pkg::tpc_cfg_t               configOut
);
    import tpc_pkg::*;

    // Refuse prescaler widths that the fixed 8-bit ratio masks cannot serve
    if (PRESCALE_WIDTH != TPC_PRESCALE_W) begin : gBadPrescaleWidth
        $error("PRESCALE_WIDTH must be 8");
    end

    // ****************************************
    // Instruction clock divider
    // ****************************************
    logic [1:0] divCount;
    logic [1:0] next_divCount;
    logic       instrTick;
    logic       next_instrClockOut;

    always_comb begin
        next_divCount      = divCount + 2'h1;
        next_instrClockOut = (next_divCount >= TPC_DIV_HALF);
        if (srst) begin
            next_divCount      = 2'h0;
            next_instrClockOut = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        divCount            <= next_divCount;
        instructionClockOut <= next_instrClockOut;
    end

    assign instrTick = (divCount == TPC_DIV_LAST);

    // ****************************************
    // External pin synchroniser and edge detect
    // ****************************************
    logic syncA;
    logic syncB;
    logic syncC;
    logic extRise;
    logic extFall;

    always_ff @(posedge clk) begin
        syncA <= externalCountInput;
        syncB <= syncA;
        syncC <= syncB;
    end

    assign extRise = syncB & ~syncC;
    assign extFall = ~syncB & syncC;

    // ****************************************
    // Configuration register
    // ****************************************
    tpc_cfg_t cfg;
    tpc_cfg_t next_cfg;

    always_comb begin
        next_cfg = cfg;
        if (srst) begin
            next_cfg = tpc_cfg_t'(TPC_CFG_RESET);
        end else if (cfgLoad) begin
            next_cfg = tpc_cfg_t'(accumulator[TPC_CFG_W-1:0]);
        end
    end

    always_ff @(posedge clk) begin
        cfg <= next_cfg;
    end

    assign configOut = cfg;

    // ****************************************
    // Source select and shared prescaler
    // ****************************************
    logic                      srcEvent;
    logic                      timerWrite;
    logic                      preEvent;
    logic                      preDone;
    logic [8:0]                preMaskWide;
    logic [7:0]                preMask;
    logic [PRESCALE_WIDTH-1:0] prescaler;
    logic [PRESCALE_WIDTH-1:0] next_prescaler;
    logic                      timerTick;
    logic                      next_wdtTick;

    always_comb begin
        srcEvent = instrTick;
        if (cfg.countSourceSelect) begin
            srcEvent = cfg.countEdgeSelect ? extFall : extRise;
        end
    end

    assign timerWrite = fileWrite && (fileAddr == TPC_TIMER_ADDR);

    assign preEvent    = cfg.prescalerAssign ? watchdogBaseTick : srcEvent;
    assign preMaskWide = cfg.prescalerAssign ? ((9'h001 << cfg.prescaleRate) - 9'h001)
                                             : ((9'h002 << cfg.prescaleRate) - 9'h001);
    assign preMask     = preMaskWide[7:0];
    assign preDone     = preEvent && ((prescaler & preMask) == preMask);

    always_comb begin
        next_prescaler = prescaler;
        next_wdtTick   = 1'b0;
        if (srst) begin
            next_prescaler = '0;
        end else if (timerWrite && !cfg.prescalerAssign) begin
            next_prescaler = '0;
        end else if (preEvent) begin
            next_prescaler = preDone ? '0 : prescaler + 8'h01;
            next_wdtTick   = preDone && cfg.prescalerAssign;
        end
    end

    always_ff @(posedge clk) begin
        prescaler             <= next_prescaler;
        watchdogPrescaledTick <= next_wdtTick;
    end

    // Timer advances on prescaler overflow or directly on each source event
    assign timerTick = cfg.prescalerAssign ? srcEvent : preDone;

    // ****************************************
    // Count register
    // ****************************************
    logic [7:0] next_timerCount;

    always_comb begin
        next_timerCount = timerCount;
        if (srst) begin
            next_timerCount = timerCount;
        end else if (timerWrite) begin
            next_timerCount = fileWdata;
        end else if (timerTick) begin
            next_timerCount = timerCount + 8'h01;
        end
    end

    // No reset: power-on value is unknown and resets keep it
    always_ff @(posedge clk) begin
        timerCount <= next_timerCount;
    end

    // Count known once written; checks on the held count wait for it
    logic countValid;
    logic next_countValid;

    always_comb begin
        next_countValid = countValid | timerWrite;
        if (srst) begin
            next_countValid = countValid;
        end
    end

    always_ff @(posedge clk) begin
        countValid <= next_countValid;
    end

    // ****************************************
    // File read port
    // ****************************************
    logic [7:0] next_fileRdata;

    always_comb begin
        next_fileRdata = 8'h00;
        if (fileRead && (fileAddr == TPC_TIMER_ADDR)) begin
            next_fileRdata = timerCount;
        end
        if (srst) begin
            next_fileRdata = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        fileRdata <= next_fileRdata;
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_CFG_RESET: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> (cfg == tpc_cfg_t'(TPC_CFG_RESET)))
        else $error("configuration not all ones after reset");

    AST_CFG_LOAD: assert property (@(posedge clk) disable iff (srst)
        cfgLoad |=> (cfg == tpc_cfg_t'($past(accumulator[5:0]))))
        else $error("configuration load did not copy accumulator");

    AST_INSTR_TICK: assert property (@(posedge clk) disable iff (srst)
        instrTick |=> !instrTick[*3] ##1 instrTick)
        else $error("instruction tick not every four cycles");

    AST_COUNT_KEEP: assert property (@(posedge clk)
        (srst && countValid) |=> (timerCount == $past(timerCount)))
        else $error("count changed during reset");

    AST_EXT_RISE: assert property (@(posedge clk) disable iff (srst)
        (cfg.countSourceSelect && !cfg.countEdgeSelect && cfg.prescalerAssign
         && syncB && !syncC && !timerWrite && !cfgLoad)
        |=> (timerCount == $past(timerCount) + 8'h01))
        else $error("rising edge not counted");

    AST_EXT_FALL: assert property (@(posedge clk) disable iff (srst)
        (cfg.countSourceSelect && cfg.countEdgeSelect && cfg.prescalerAssign
         && !syncB && syncC && !timerWrite && !cfgLoad)
        |=> (timerCount == $past(timerCount) + 8'h01))
        else $error("falling edge not counted");

    AST_INT_IDLE: assert property (@(posedge clk) disable iff (srst)
        (!cfg.countSourceSelect && !instrTick && !timerWrite)
        |=> (timerCount == $past(timerCount)))
        else $error("internal source counted off the instruction tick");

    AST_TIMER_DIV2: assert property (@(posedge clk) disable iff (srst)
        (!cfg.prescalerAssign && cfg.prescaleRate == 3'h0 && srcEvent
         && !timerWrite && !cfgLoad)
        |=> (timerCount == $past(timerCount) + 8'($past(prescaler[0]))))
        else $error("timer rate 1:2 wrong");

    AST_WDT_DIV1: assert property (@(posedge clk) disable iff (srst)
        (cfg.prescalerAssign && cfg.prescaleRate == 3'h0 && watchdogBaseTick && !cfgLoad)
        |=> watchdogPrescaledTick)
        else $error("watchdog rate 1:1 wrong");

    AST_READ_COUNT: assert property (@(posedge clk) disable iff (srst)
        (fileRead && fileAddr == TPC_TIMER_ADDR) |=> (fileRdata == $past(timerCount)))
        else $error("count read wrong");

    AST_READ_OTHER: assert property (@(posedge clk) disable iff (srst)
        (fileRead && fileAddr != TPC_TIMER_ADDR) |=> (fileRdata == 8'h00))
        else $error("non-count address read not zero");

    AST_CFG_HOLD: assert property (@(posedge clk) disable iff (srst)
        !cfgLoad |=> (cfg == $past(cfg)))
        else $error("configuration changed without a load");

    AST_WRITE_COUNT: assert property (@(posedge clk) disable iff (srst)
        timerWrite |=> (timerCount == $past(fileWdata)))
        else $error("count write not taken");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (srst)
        !fileRead |=> (fileRdata == 8'h00))
        else $error("read data not zero without a read");

    AST_WDT_QUIET: assert property (@(posedge clk) disable iff (srst)
        !cfg.prescalerAssign |=> !watchdogPrescaledTick)
        else $error("watchdog tick while prescaler is on the timer");

    AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (srst)
        (timerWrite && !cfg.prescalerAssign) |=> (prescaler == '0))
        else $error("count write did not clear the prescaler");

    AST_INT_DIRECT: assert property (@(posedge clk) disable iff (srst)
        (!cfg.countSourceSelect && cfg.prescalerAssign && instrTick && !timerWrite)
        |=> (timerCount == $past(timerCount) + 8'h01))
        else $error("direct internal count missed an instruction tick");

    AST_EDGE_IGNORE: assert property (@(posedge clk) disable iff (srst)
        (cfg.countSourceSelect && !cfg.countEdgeSelect && cfg.prescalerAssign
         && extFall && !timerWrite)
        |=> (timerCount == $past(timerCount)))
        else $error("falling edge counted while rising edges selected");

    AST_INSTRUCTION_CLOCK_OUT_RESET: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> (!instructionClockOut && divCount == 2'h0))
        else $error("instruction clock not restarted by reset");

endmodule

// [include/tpc_pkg.sv]
// Package: constants and types for the timer and prescaler configuration block
package tpc_pkg;

    // ****************************************
    // File register map
    // ****************************************
    localparam logic [4:0] TPC_TIMER_ADDR     = 5'h01;
    localparam int         TPC_FILE_AW        = 5;
    localparam int         TPC_DATA_W         = 8;

    // ****************************************
    // Configuration layout and reset value
    // ****************************************
    localparam int         TPC_CFG_W          = 6;
    localparam int         TPC_CFG_SRC_BIT    = 5;
    localparam int         TPC_CFG_EDGE_BIT   = 4;
    localparam int         TPC_CFG_ASSIGN_BIT = 3;
    localparam int         TPC_CFG_RATE_LSB   = 0;
    localparam int         TPC_CFG_RATE_W     = 3;
    localparam logic [5:0] TPC_CFG_RESET      = 6'h3f;

    // ****************************************
    // Timing
    // ****************************************
    localparam int         TPC_CLK_PERIOD_NS  = 10;
    localparam int         TPC_OSC_PER_INSTR  = 4;
    localparam int         TPC_INSTR_CYCLES   = TPC_OSC_PER_INSTR;
    localparam logic [1:0] TPC_DIV_LAST       = 2'(TPC_INSTR_CYCLES - 1);
    localparam logic [1:0] TPC_DIV_HALF       = 2'(TPC_INSTR_CYCLES / 2);
    localparam int         TPC_PRESCALE_W     = 8;

    // Configuration fields, bit 5 down to bit 0
    typedef struct packed {
        logic       countSourceSelect;
        logic       countEdgeSelect;
        logic       prescalerAssign;
        logic [2:0] prescaleRate;
    } tpc_cfg_t;

endpackage

// [verif/tpc_ext_src.sv]
// Partner model: pulse source that drives the external count pin
`timescale 1ns/1ns
module tpc_ext_src #(
    parameter int HOLD = 4
) (
    // Clock
    input  wire logic       clk,
    // Control from bench
    input  wire logic       start,
    input  wire logic [3:0] toggles,
    // Pin side
    output logic            pin,
    output logic            busy
);
    int left = 0;
    int wait_cnt = 0;
    initial pin = 1'b0;
    assign busy = (left != 0);
    // Toggle the pin, HOLD+1 cycles per level so the synchroniser sees each one
    always @(posedge clk) begin
        if (start) begin
            left <= toggles;
            wait_cnt <= HOLD;
        end else if (left != 0) begin
            if (wait_cnt == 0) begin
                pin <= !pin;
                left <= left - 1;
                wait_cnt <= HOLD;
            end else begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

// [verif/timer_prescaler_config_tb.sv]
// Testbench: self-checking bench for the timer and prescaler configuration block
`timescale 1ns/1ns
module timer_prescaler_config_tb;
    import tpc_pkg::*;
    logic clk, srst, cfgLoad, fileWrite, fileRead, extPin, wdBase, wdTick, instruction_clock_out, start, busy;
    logic [7:0] accumulator, fileWdata, fileRdata, timerCount, q, d;
    logic [4:0] fileAddr;
    logic [3:0] toggles;
    tpc_cfg_t   cfgOut;
    int errorCnt = 0, checked = 0, cyc = 0, wdCnt = 0, n, expCount, lvl, e;
    tpc_timer i_dut (.clk(clk), .srst(srst), .cfgLoad(cfgLoad), .accumulator(accumulator),
        .fileAddr(fileAddr), .fileWrite(fileWrite), .fileRead(fileRead), .fileWdata(fileWdata),
        .fileRdata(fileRdata), .externalCountInput(extPin), .watchdogBaseTick(wdBase),
        .watchdogPrescaledTick(wdTick), .timerCount(timerCount),
        .instructionClockOut(instruction_clock_out), .configOut(cfgOut));
    tpc_ext_src i_src (.clk(clk), .start(start), .toggles(toggles), .pin(extPin), .busy(busy));
    // ****************************************
    // Clock, timeout, tick counter
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (wdTick === 1'b1) wdCnt++;
        if (cyc > 40000) begin
            errorCnt++;
            stopTest();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic stopTest();
        $display("checked=%0d errorCnt=%0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] ex, input logic [15:0] ac);
        checked++;
        if (ex !== ac) begin
            errorCnt++;
            $display("[ERR] t=%0t exp=%h act=%h", $time, ex, ac);
        end
    endtask
    task automatic load(input logic [7:0] v);
        @(posedge clk);
        cfgLoad <= 1'b1;
        accumulator <= v;
        @(posedge clk);
        cfgLoad <= 1'b0;
        #1;
        chk({10'h0, v[5:0]}, {10'h0, cfgOut});
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] wd);
        @(posedge clk);
        fileWrite <= w;
        fileRead <= !w;
        fileAddr <= a;
        fileWdata <= wd;
        @(posedge clk);
        fileWrite <= 1'b0;
        fileRead <= 1'b0;
        #1;
        q = fileRdata;
    endtask
    task automatic rst();
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'h3f, {10'h0, cfgOut});
    endtask
    task automatic gap(output int g);
        logic [7:0] p;
        for (int k = 0; k < 2; k++) begin
            p = timerCount;
            g = 0;
            while (timerCount === p && g < 3000) begin
                @(posedge clk);
                #1;
                g++;
            end
        end
    endtask
    task automatic run(input int t);
        @(posedge clk);
        start <= 1'b1;
        toggles <= 4'(t);
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < t; k++) begin
            lvl = 1 - lvl;
            if (lvl == 1 - e) expCount++;
        end
        n = 0;
        #1;
        while (busy === 1'b1 && n < 500) begin
            @(posedge clk);
            #1;
            n++;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {srst, cfgLoad, fileWrite, fileRead, wdBase, start} = 6'h20;
        {accumulator, fileWdata, fileAddr, toggles} = '0;
        lvl = 0;
        void'($urandom(32'h3070));
        rst();
        d = 8'($urandom);
        acc(1'b1, TPC_TIMER_ADDR, d);
        acc(1'b1, 5'h02, ~d);
        acc(1'b0, TPC_TIMER_ADDR, 8'h00);
        chk({8'h0, d}, {8'h0, q});
        acc(1'b0, 5'h00, 8'h00);
        chk(16'h0, {8'h0, q});
        rst();
        acc(1'b0, TPC_TIMER_ADDR, 8'h00);
        chk({8'h0, d}, {8'h0, q});
        n = 0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1;
            n += int'(instruction_clock_out === 1'b1);
        end
        chk(16'd2, 16'(n));
        for (int r = 0; r < 8; r++) begin
            load({2'($urandom), 3'b000, 3'(r)});
            acc(1'b1, TPC_TIMER_ADDR, 8'($urandom));
            gap(n);
            chk(16'(4 << (r + 1)), 16'(n));
        end
        load({2'($urandom), 3'b001, 3'($urandom)});
        gap(n);
        chk(16'd4, 16'(n));
        for (int r = 0; r < 4; r++) begin
            rst();
            load({2'h0, 3'b001, 3'(r)});
            wdCnt = 0;
            repeat (2 << r) begin
                @(posedge clk);
                wdBase <= 1'b1;
                @(posedge clk);
                wdBase <= 1'b0;
                repeat ($urandom % 3) @(posedge clk);
            end
            repeat (3) @(posedge clk);
            #1;
            chk(16'd2, 16'(wdCnt));
        end
        for (e = 0; e < 2; e++) begin
            load({2'h0, 1'b1, 1'(e), 1'b1, 3'($urandom)});
            expCount = 0;
            acc(1'b1, TPC_TIMER_ADDR, 8'h00);
            run(5);
            run(5);
            chk(16'(expCount), {8'h0, timerCount});
        end
        load(8'h20);
        acc(1'b1, TPC_TIMER_ADDR, 8'h00);
        run(8);
        chk(16'd2, {8'h0, timerCount});
        stopTest();
    end
endmodule
